// ==== hw/pps_dev.sv ====
`timescale 1ns/1ps
module pps_dev #(
	parameter int WIDTH = pps_pkg::WORD_W
)(
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	pps_if.dev               link,
	output logic [3:0]       o_array_in,
	output logic             o_prog_active,
	output logic [WIDTH-1:0] o_word,
	output logic             o_word_valid,
	output logic             o_frame_err
);
	import pps_pkg::*;

	localparam int CW = $clog2(WIDTH + 1);

	// Shift clock domain
	logic [1:0]       en_s_reg;
	logic             prog_s;
	pps_dev_st_t      st_reg;
	logic [WIDTH-1:0] sr_reg;
	logic [WIDTH-1:0] hold_reg;
	logic [CW-1:0]    bits_reg;
	logic             hold_err_reg;
	logic             xfer_tgl_reg;
	logic             rb_reg;

	// System clock domain
	logic [1:0]       en_c_reg;
	logic [3:0]       pin_s1_reg;
	logic [3:0]       pin_s2_reg;
	logic [2:0]       tgl_s_reg;
	logic             oe_n_reg;
	logic             xfer_seen;

	// Enable high clears this synchroniser at once; release passes two shift
	// clock flops, so the first setup beats still clear the shift register
	always_ff @(posedge link.sclk or posedge link.prog_enable_n)
	begin
		if (link.prog_enable_n)
			en_s_reg <= '0;
		else
			en_s_reg <= {en_s_reg[0], 1'b1};
	end

	assign prog_s = en_s_reg[1];

	// Command decode on the rising shift clock edge
	always_ff @(posedge link.sclk)
	begin
		if (!prog_s)
		begin
			st_reg <= DS_IDLE;
		end
		else
		begin
			case (st_reg)
				DS_IDLE:
				begin
					if (link.mode_sel && !link.serial_prog_in)
						st_reg <= DS_SHIFT;
				end
				DS_SHIFT:
				begin
					if (link.mode_sel)
						st_reg <= DS_UPDATE;
				end
				DS_UPDATE:
				begin
					if (!link.mode_sel)
						st_reg <= DS_SHIFT;
					else
						st_reg <= DS_IDLE;
				end
				default:
				begin
					st_reg <= DS_IDLE;
				end
			endcase
		end
	end

	// Serial shift register, clocked only by the programmer's shift clock
	always_ff @(posedge link.sclk)
	begin
		if (!prog_s)
		begin
			sr_reg <= '0;
		end
		else if (st_reg == DS_SHIFT && !link.mode_sel)
		begin
			sr_reg <= {sr_reg[WIDTH-2:0], link.serial_prog_in};
		end
	end

	// Bits shifted since the last command, to flag short or long words
	always_ff @(posedge link.sclk)
	begin
		if (!prog_s || st_reg != DS_SHIFT)
		begin
			bits_reg <= '0;
		end
		else if (!link.mode_sel && bits_reg != CW'(WIDTH + 1))
		begin
			bits_reg <= bits_reg + CW'(1);
		end
	end

	// Word hand-off: data held stable, event carried by a toggle
	always_ff @(posedge link.sclk)
	begin
		if (prog_s && st_reg == DS_SHIFT && link.mode_sel)
		begin
			hold_reg     <= sr_reg;
			hold_err_reg <= (bits_reg != CW'(WIDTH));
		end
	end

	// The toggle needs a known start, so enable high clears it; the system
	// side masks the false event this makes at the end of a session
	always_ff @(posedge link.sclk or posedge link.prog_enable_n)
	begin
		if (link.prog_enable_n)
			xfer_tgl_reg <= 1'b0;
		else if (prog_s && st_reg == DS_SHIFT && link.mode_sel)
			xfer_tgl_reg <= ~xfer_tgl_reg;
	end

	// Output changes on the falling edge so the programmer has a full half
	// period of setup before it samples on the next rising edge
	always_ff @(negedge link.sclk)
	begin
		if (!prog_s)
			rb_reg <= OUT_IDLE;
		else
			rb_reg <= sr_reg[WIDTH-1];
	end

	assign link.rb_dev      = rb_reg;
	assign link.rb_dev_oe_n = oe_n_reg;

	// Pin and enable synchronisers in the system domain
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			en_c_reg   <= '0;
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
		end
		else
		begin
			en_c_reg   <= {en_c_reg[0], ~link.prog_enable_n};
			pin_s1_reg[PIN_IN]   <= link.serial_prog_in;
			pin_s1_reg[PIN_MODE] <= link.mode_sel;
			pin_s1_reg[PIN_OUT]  <= link.serial_prog_out;
			pin_s1_reg[PIN_CLK]  <= link.sclk;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// Pin roles follow the enable; the array sees zeros while programming
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_array_in    <= '0;
			o_prog_active <= 1'b0;
			oe_n_reg      <= 1'b1;
		end
		else
		begin
			o_prog_active <= en_c_reg[1];
			oe_n_reg      <= ~en_c_reg[1];
			if (en_c_reg[1])
				o_array_in <= '0;
			else
				o_array_in <= pin_s2_reg;
		end
	end

	// Toggle synchroniser for the word event
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			tgl_s_reg <= '0;
		else
			tgl_s_reg <= {tgl_s_reg[1:0], xfer_tgl_reg};
	end

	assign xfer_seen = tgl_s_reg[2] ^ tgl_s_reg[1];

	// Hold data is stable for many system clocks after its toggle, so it is
	// sampled directly once the toggle has crossed
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_word       <= '0;
			o_word_valid <= 1'b0;
			o_frame_err  <= 1'b0;
		end
		else
		begin
			o_word_valid <= xfer_seen && en_c_reg[1] && !hold_err_reg;
			o_frame_err  <= xfer_seen && en_c_reg[1] && hold_err_reg;
			if (xfer_seen && en_c_reg[1])
				o_word <= hold_reg;
		end
	end
endmodule

// ==== hw/pps_fifo.sv ====
`timescale 1ns/1ps
module pps_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)(
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_in_data,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	output logic [WIDTH-1:0]      o_out_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic [AW:0]      cnt_next;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	assign o_out_valid = (cnt_reg != '0);
	assign o_out_data  = mem_reg[rd_reg];

	always_comb
	begin
		cnt_next = cnt_reg;
		if (push && !pop)
			cnt_next = cnt_reg + (AW+1)'(1);
		else if (pop && !push)
			cnt_next = cnt_reg - (AW+1)'(1);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			wr_reg     <= '0;
			rd_reg     <= '0;
			cnt_reg    <= '0;
			o_in_ready <= 1'b0;
		end
		else
		begin
			if (push)
				wr_reg <= ptr_inc(wr_reg);
			if (pop)
				rd_reg <= ptr_inc(rd_reg);
			cnt_reg    <= cnt_next;
			o_in_ready <= (cnt_next != FULL_CNT);
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (push)
			mem_reg[wr_reg] <= i_in_data;
	end
endmodule

// ==== hw/pps_prog.sv ====
`timescale 1ns/1ps
module pps_prog #(
	parameter int WIDTH = pps_pkg::WORD_W,
	parameter int DEPTH = pps_pkg::FIFO_DEPTH,
	parameter int HALF  = pps_pkg::SCLK_HALF
)(
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	pps_if.prog                   link,
	input  wire logic [WIDTH-1:0] i_word,
	input  wire logic             i_word_valid,
	output logic                  o_word_ready,
	input  wire logic [3:0]       i_pass,
	output logic [WIDTH-1:0]      o_rd_word,
	output logic                  o_rd_valid,
	output logic                  o_busy
);
	import pps_pkg::*;

	localparam int PW = $clog2(2 * HALF);
	localparam int BW = $clog2(WIDTH + SETUP_BEATS);

	pps_host_st_t     st_reg;
	logic [PW-1:0]    ph_reg;
	logic [BW-1:0]    bcnt_reg;
	logic [WIDTH-1:0] data_reg;
	logic [WIDTH-1:0] rd_sh_reg;
	logic [1:0]       rb_s_reg;
	logic             sclk_reg;
	logic             en_n_reg;
	logic             din_reg;
	logic             mode_reg;
	logic             hsdo_reg;
	logic             hsdo_oe_n_reg;
	logic [WIDTH-1:0] f_data;
	logic             f_valid;
	logic             beat_end;
	logic             pop;

	assign beat_end = (ph_reg == PW'(2 * HALF - 1));
	assign pop      = (st_reg == HS_ENTER) && beat_end;

	pps_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) i_pps_fifo (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.i_in_data   (i_word),
		.i_in_valid  (i_word_valid),
		.o_in_ready  (o_word_ready),
		.o_out_data  (f_data),
		.o_out_valid (f_valid),
		.i_out_ready (pop)
	);

	assign link.prog_enable_n  = en_n_reg;
	assign link.sclk           = sclk_reg;
	assign link.serial_prog_in = din_reg;
	assign link.mode_sel       = mode_reg;
	assign link.rb_host        = hsdo_reg;
	assign link.rb_host_oe_n   = hsdo_oe_n_reg;

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			rb_s_reg <= '0;
		else
			rb_s_reg <= {rb_s_reg[0], link.serial_prog_out};
	end

	// Each beat is one shift clock period: low half first, then high half.
	// Outputs change at the falling edge, the device samples on the rising.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			st_reg        <= HS_IDLE;
			ph_reg        <= '0;
			bcnt_reg      <= '0;
			data_reg      <= '0;
			rd_sh_reg     <= '0;
			sclk_reg      <= 1'b0;
			en_n_reg      <= 1'b1;
			din_reg       <= 1'b0;
			mode_reg      <= 1'b0;
			hsdo_reg      <= 1'b0;
			hsdo_oe_n_reg <= 1'b1;
			o_rd_word     <= '0;
			o_rd_valid    <= 1'b0;
			o_busy        <= 1'b0;
		end
		else
		begin
			o_rd_valid <= 1'b0;
			o_busy     <= (st_reg != HS_IDLE);
			case (st_reg)
				HS_IDLE:
				begin
					// Outside programming the pins carry plain logic inputs
					en_n_reg      <= 1'b1;
					din_reg       <= i_pass[PIN_IN];
					mode_reg      <= i_pass[PIN_MODE];
					hsdo_reg      <= i_pass[PIN_OUT];
					hsdo_oe_n_reg <= 1'b0;
					sclk_reg      <= i_pass[PIN_CLK];
					ph_reg        <= '0;
					if (f_valid)
					begin
						st_reg        <= HS_SETUP;
						en_n_reg      <= 1'b0;
						hsdo_oe_n_reg <= 1'b1;
						sclk_reg      <= 1'b0;
						mode_reg      <= 1'b1;
						din_reg       <= 1'b1;
						bcnt_reg      <= BW'(SETUP_BEATS - 1);
					end
				end
				default:
				begin
					ph_reg <= beat_end ? '0 : ph_reg + PW'(1);
					if (ph_reg == PW'(HALF - 1))
					begin
						sclk_reg <= 1'b1;
						if (st_reg == HS_SHIFT)
							rd_sh_reg <= {rd_sh_reg[WIDTH-2:0], rb_s_reg[1]};
					end
					if (beat_end)
					begin
						sclk_reg <= 1'b0;
						case (st_reg)
							HS_SETUP:
							begin
								if (bcnt_reg == '0)
								begin
									st_reg   <= HS_ENTER;
									mode_reg <= 1'b1;
									din_reg  <= 1'b0;
								end
								else
									bcnt_reg <= bcnt_reg - BW'(1);
							end
							HS_ENTER:
							begin
								st_reg   <= HS_SHIFT;
								mode_reg <= 1'b0;
								din_reg  <= f_data[WIDTH-1];
								data_reg <= {f_data[WIDTH-2:0], 1'b0};
								bcnt_reg <= BW'(WIDTH - 1);
							end
							HS_SHIFT:
							begin
								if (bcnt_reg == '0)
								begin
									st_reg   <= HS_UPD;
									mode_reg <= 1'b1;
									din_reg  <= 1'b0;
								end
								else
								begin
									bcnt_reg <= bcnt_reg - BW'(1);
									din_reg  <= data_reg[WIDTH-1];
									data_reg <= {data_reg[WIDTH-2:0], 1'b0};
								end
							end
							HS_UPD:
							begin
								st_reg     <= HS_EXIT;
								mode_reg   <= 1'b1;
								din_reg    <= 1'b1;
								o_rd_word  <= rd_sh_reg;
								o_rd_valid <= 1'b1;
							end
							HS_EXIT:
							begin
								if (f_valid)
								begin
									st_reg   <= HS_ENTER;
									mode_reg <= 1'b1;
									din_reg  <= 1'b0;
								end
								else
									st_reg <= HS_IDLE;
							end
							default:
							begin
								st_reg <= HS_IDLE;
							end
						endcase
					end
				end
			endcase
		end
	end
endmodule

// ==== inc/pps_if.sv ====
`timescale 1ns/1ps
interface pps_if;
	logic prog_enable_n;
	logic sclk;
	logic serial_prog_in;
	logic mode_sel;
	logic rb_dev;
	logic rb_dev_oe_n;
	logic rb_host;
	logic rb_host_oe_n;
	logic serial_prog_out;

	// Pull-up level when nobody drives the shared output pin
	assign serial_prog_out = !rb_dev_oe_n ? rb_dev : (!rb_host_oe_n ? rb_host : 1'b1);

	modport dev
	(
		input  prog_enable_n,
		input  sclk,
		input  serial_prog_in,
		input  mode_sel,
		input  serial_prog_out,
		output rb_dev,
		output rb_dev_oe_n
	);

	modport prog
	(
		output prog_enable_n,
		output sclk,
		output serial_prog_in,
		output mode_sel,
		output rb_host,
		output rb_host_oe_n,
		input  serial_prog_out
	);
endinterface

// ==== inc/pps_pkg.sv ====
package pps_pkg;
	localparam int WORD_W      = 8;
	localparam int FIFO_DEPTH  = 8;
	// Half period of the shift clock in system clocks; at least 3 so that
	// the two-stage read-back synchroniser settles before the rising edge
	localparam int SCLK_HALF   = 4;
	// Beats with enable low before the first command, covering the
	// two-flop enable synchroniser on the shift clock side
	localparam int SETUP_BEATS = 4;
	localparam int PIN_IN      = 0;
	localparam int PIN_MODE    = 1;
	localparam int PIN_OUT     = 2;
	localparam int PIN_CLK     = 3;
	localparam logic OUT_IDLE  = 1'b1;

	typedef enum logic [1:0]
	{
		DS_IDLE   = 2'b00,
		DS_SHIFT  = 2'b01,
		DS_UPDATE = 2'b10
	} pps_dev_st_t;

	typedef enum logic [2:0]
	{
		HS_IDLE  = 3'b000,
		HS_SETUP = 3'b001,
		HS_ENTER = 3'b010,
		HS_SHIFT = 3'b011,
		HS_UPD   = 3'b100,
		HS_EXIT  = 3'b101
	} pps_host_st_t;
endpackage

// ==== verif/pps_link_asserts.sv ====
`timescale 1ns/1ps
module pps_link_asserts
	import pps_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_sys_rst,
	input wire logic       prog_enable_n,
	input wire logic       sclk,
	input wire logic       serial_prog_in,
	input wire logic       mode_sel,
	input wire logic       rb_dev,
	input wire logic       rb_dev_oe_n,
	input wire logic       serial_prog_out,
	input wire logic [3:0] o_array_in,
	input wire logic       o_prog_active
);
	int shift_cnt;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// Shift clock is a register of this domain, so its edges are seen here
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || prog_enable_n)
			shift_cnt <= 0;
		else if ($rose(sclk))
			shift_cnt <= mode_sel ? 0 : shift_cnt + 1;
	end

	entry_pins_a: assert property
		($fell(prog_enable_n) |-> mode_sel && serial_prog_in && !sclk)
		else $error("entry pins wrong");
	enter_active_a: assert property
		($fell(prog_enable_n) |-> ##[1:4] o_prog_active)
		else $error("programming not active");
	array_quiet_a: assert property
		(o_prog_active && $past(o_prog_active) |-> o_array_in == 4'h0)
		else $error("array sees pins while programming");
	array_pass_a: assert property
		((prog_enable_n && $stable({sclk, serial_prog_out, mode_sel, serial_prog_in}))[*8]
		|-> o_array_in == {sclk, serial_prog_out, mode_sel, serial_prog_in})
		else $error("array inputs do not follow pins");
	out_release_a: assert property
		(prog_enable_n[*6] |-> rb_dev_oe_n)
		else $error("out pin driven in normal mode");
	out_drive_a: assert property
		((!prog_enable_n)[*6] |-> !rb_dev_oe_n)
		else $error("out pin not driven while programming");
	out_edge_a: assert property
		(!prog_enable_n && $changed(rb_dev) |-> $fell(sclk))
		else $error("read-back changed off the falling edge");
	pin_hold_a: assert property
		(!prog_enable_n && $past(!prog_enable_n) && $changed({serial_prog_in, mode_sel})
		|-> $fell(sclk))
		else $error("control pins changed mid beat");
	half_beat_a: assert property
		($rose(sclk) && !prog_enable_n |-> sclk[*4] ##1 !sclk)
		else $error("shift clock high time wrong");
	shift_len_a: assert property
		($rose(sclk) && mode_sel && shift_cnt != 0 |-> shift_cnt == WORD_W)
		else $error("shift run length wrong");

	cover property ($fell(prog_enable_n));
	cover property ($rose(prog_enable_n));
	cover property (shift_cnt == WORD_W);
endmodule

// ==== verif/prog_port_pin_sharing_bench.sv ====
`timescale 1ns/1ps
module prog_port_pin_sharing_bench;
	import pps_pkg::*;
	localparam logic [WORD_W-1:0] WORDS [10] =
		'{8'hA5, 8'h3C, 8'hFF, 8'h00, 8'h81, 8'h5A, 8'hC3, 8'h7E, 8'h01, 8'h80};
	logic              i_clk = 1'b0;
	logic              i_sys_rst = 1'b1;
	logic [WORD_W-1:0] word = '0;
	logic              word_valid = 1'b0;
	logic [3:0]        pass = 4'h0;
	logic              word_ready, rd_valid, busy, prog_active, dev_valid, frame_err;
	logic [WORD_W-1:0] rd_word, dev_word, in_sr, out_sr;
	logic [3:0]        array_in;
	logic [WORD_W-1:0] sent_q[$], dev_q[$], rd_q[$], in_q[$], out_q[$];
	logic              full_seen = 1'b0;
	int                mismatches = 0;
	int                checked = 0;
	int                cycles = 0;
	int                bits = 0;

	pps_if link_if();

	pps_dev i_pps_dev
	(
		.i_clk         (i_clk),
		.i_sys_rst     (i_sys_rst),
		.link          (link_if.dev),
		.o_array_in    (array_in),
		.o_prog_active (prog_active),
		.o_word        (dev_word),
		.o_word_valid  (dev_valid),
		.o_frame_err   (frame_err)
	);

	pps_prog i_pps_prog
	(
		.i_clk        (i_clk),
		.i_sys_rst    (i_sys_rst),
		.link         (link_if.prog),
		.i_word       (word),
		.i_word_valid (word_valid),
		.o_word_ready (word_ready),
		.i_pass       (pass),
		.o_rd_word    (rd_word),
		.o_rd_valid   (rd_valid),
		.o_busy       (busy)
	);

	pps_link_asserts i_pps_link_asserts
	(
		.i_clk           (i_clk),
		.i_sys_rst       (i_sys_rst),
		.prog_enable_n   (link_if.prog_enable_n),
		.sclk            (link_if.sclk),
		.serial_prog_in  (link_if.serial_prog_in),
		.mode_sel        (link_if.mode_sel),
		.rb_dev          (link_if.rb_dev),
		.rb_dev_oe_n     (link_if.rb_dev_oe_n),
		.serial_prog_out (link_if.serial_prog_out),
		.o_array_in      (array_in),
		.o_prog_active   (prog_active)
	);

	always #50 i_clk = ~i_clk;

	task automatic finish_test();
		$display("counts: %0d checked, %0d mismatches", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [WORD_W-1:0] seen,
		input logic [WORD_W-1:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	// Valid stays up between words; ready read after the edge is what the next edge sees
	task automatic push(input logic [WORD_W-1:0] w);
		int n;
		n = 0;
		word = w;
		word_valid = 1'b1;
		while (word_ready !== 1'b1 && n < 2000)
		begin
			step(1);
			n++;
		end
		step(1);
		sent_q.push_back(w);
	endtask

	task automatic drain(input int n);
		int t;
		t = 0;
		while ((dev_q.size() < n || rd_q.size() < n || busy !== 1'b0) && t < 4000)
		begin
			step(1);
			t++;
		end
		check("words seen", WORD_W'(dev_q.size()), WORD_W'(n));
	endtask

	task automatic compare(input int first);
		logic [WORD_W-1:0] prev;
		prev = '0;
		for (int i = first; i < sent_q.size(); i++)
		begin
			check("device word", dev_q[i], sent_q[i]);
			check("wire word", in_q[i], sent_q[i]);
			check("readback", rd_q[i], prev);
			check("out pin", out_q[i], prev);
			prev = sent_q[i];
		end
	endtask

	task automatic pins(input logic [3:0] v);
		pass = v;
		step(12);
		check("array inputs", WORD_W'(array_in), WORD_W'(v));
		check("active", WORD_W'(prog_active), '0);
	endtask

	// Sampled on the falling clock so pulses launched at the rising edge have settled
	always @(negedge i_clk)
	begin
		cycles++;
		if (dev_valid === 1'b1 || frame_err !== 1'b0)
			check("frame error", WORD_W'(frame_err), '0);
		if (dev_valid === 1'b1)
			dev_q.push_back(dev_word);
		if (rd_valid === 1'b1)
			rd_q.push_back(rd_word);
		if (word_valid && word_ready === 1'b0)
			full_seen = 1'b1;
		if (cycles == 8000)
		begin
			mismatches++;
			finish_test();
		end
	end

	// Wire view: both pins only move on the falling shift clock
	always @(posedge link_if.sclk)
	begin
		if (link_if.prog_enable_n)
			bits = 0;
		else if (!link_if.mode_sel)
		begin
			in_sr = {in_sr[WORD_W-2:0], link_if.serial_prog_in};
			out_sr = {out_sr[WORD_W-2:0], link_if.serial_prog_out};
			bits++;
		end
		else if (bits != 0)
		begin
			in_q.push_back(in_sr);
			out_q.push_back(out_sr);
			bits = 0;
		end
	end

	initial
	begin
		step(4);
		i_sys_rst = 1'b0;
		for (int v = 0; v < 16; v++)
			pins(v[3:0]);
		$display("test normal pins done");
		pass = 4'h0;
		step(4);
		for (int i = 0; i < 10; i++)
			push(WORDS[i]);
		word_valid = 1'b0;
		drain(10);
		check("fifo refused", WORD_W'(full_seen), WORD_W'(1));
		compare(0);
		$display("test word stream done");
		pins(4'h6);
		push(8'h96);
		word_valid = 1'b0;
		drain(11);
		compare(10);
		$display("test second session done");
		finish_test();
	end
endmodule
